//--- lsg_top.sv
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "lsg_regs.svh"

module lsg_top (
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // AXI4-Lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   // AXI4-Lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   // AXI4-Lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Comparator
   input wire logic raw_below_fall,
   input wire logic raw_above_rise,
   output logic trip_range_select,
   output logic monitor_enable,
   // Low-power modes
   input wire logic wait_mode,
   input wire logic stop_mode,
   // System reset request
   output logic reset_request
);

   ////////////////////////////////////////////////////////////////////////
   // Synchroniser
   lsg_sync_if sif ();

   lsg_sync #(
      .STAGES(`LSG_SYNC_STAGES)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .raw_below_fall(raw_below_fall),
      .raw_above_rise(raw_above_rise),
      .sif(sif)
   );

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic aw_have_q, aw_have_d;
   logic [7:0] awaddr_q, awaddr_d;
   logic w_have_q, w_have_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic bvalid_q, bvalid_d;
   lsg_pkg::lsg_resp_t bresp_q, bresp_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   lsg_pkg::lsg_resp_t rresp_q, rresp_d;

   logic [`LSG_CFG_W-1:0] cfg_q, cfg_d;
   logic locked_q, locked_d;
   logic flag_q, flag_d;
   lsg_pkg::lsg_mon_state_t state_q, state_d;

   logic do_write;
   logic cfg_wr;
   logic active;
   logic reset_ok;
   logic [7:0] status_byte;
   logic [7:0] wr_word;
   logic unused_ok;

   assign unused_ok = &{1'b0, awprot, arprot, wait_mode, awaddr_q[1:0], wdata_q[31:4], wstrb_q[3:1]};

   ////////////////////////////////////////////////////////////////////////
   // Bus handshakes
   assign awready = ce & ~aw_have_q & ~bvalid_q;
   assign wready = ce & ~w_have_q & ~bvalid_q;
   assign arready = ce & ~rvalid_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;

   assign do_write = aw_have_q & w_have_q & ~bvalid_q;
   assign wr_word = {awaddr_q[7:2], 2'h0};
   assign cfg_wr = ce & do_write & (wr_word == `LSG_OFS_CONFIG) & wstrb_q[0] & ~locked_q;

   ////////////////////////////////////////////////////////////////////////
   // Monitor activity
   // Wait mode does not stop the monitor; stop mode needs stop enable
   assign active = ~cfg_q[`LSG_CFG_PWR_DIS] & (~stop_mode | cfg_q[`LSG_CFG_STOP_EN]);
   assign reset_ok = active & ~cfg_q[`LSG_CFG_RST_DIS];
   assign monitor_enable = active;
   assign trip_range_select = cfg_q[`LSG_CFG_TRIP_SEL];

   assign status_byte = {4'h0, active, locked_q, state_q == lsg_pkg::LSG_MON_RESET, flag_q};

   ////////////////////////////////////////////////////////////////////////
   // Bus slave
   always_comb
   begin
      aw_have_d = aw_have_q;
      awaddr_d = awaddr_q;
      w_have_d = w_have_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (awvalid && awready)
      begin
         aw_have_d = 1'b1;
         awaddr_d = awaddr;
      end
      if (wvalid && wready)
      begin
         w_have_d = 1'b1;
         wdata_d = wdata;
         wstrb_d = wstrb;
      end
      if (do_write)
      begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         if (wr_word == `LSG_OFS_CONFIG)
            bresp_d = `LSG_RESP_OKAY;
         else
            bresp_d = `LSG_RESP_SLVERR;
      end
      else if (bvalid_q && bready)
      begin
         bvalid_d = 1'b0;
      end
      if (arvalid && arready)
      begin
         rvalid_d = 1'b1;
         case ({araddr[7:2], 2'h0})
            `LSG_OFS_STATUS:
            begin
               rdata_d = {24'h000000, status_byte};
               rresp_d = `LSG_RESP_OKAY;
            end
            `LSG_OFS_CONFIG:
            begin
               rdata_d = {28'h0000000, cfg_q};
               rresp_d = `LSG_RESP_OKAY;
            end
            default:
            begin
               rdata_d = 32'h00000000;
               rresp_d = `LSG_RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid_q && rready)
      begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         awaddr_q <= 8'h00;
         w_have_q <= 1'b0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `LSG_RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `LSG_RESP_OKAY;
      end
      else if (ce)
      begin
         aw_have_q <= aw_have_d;
         awaddr_q <= awaddr_d;
         w_have_q <= w_have_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write-once configuration
   always_comb
   begin
      cfg_d = cfg_q;
      locked_d = locked_q;
      if (cfg_wr)
      begin
         cfg_d = wdata_q[`LSG_CFG_W-1:0];
         locked_d = 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cfg_q <= `LSG_CFG_RESET;
         locked_q <= 1'b0;
      end
      else if (ce)
      begin
         cfg_q <= cfg_d;
         locked_q <= locked_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Flag and reset request
   always_comb
   begin
      flag_d = flag_q;
      state_d = state_q;
      if (active)
      begin
         if (sif.below_fall)
            flag_d = 1'b1;
         else if (sif.above_rise)
            flag_d = 1'b0;
      end
      case (state_q)
         lsg_pkg::LSG_MON_RUN:
         begin
            if (reset_ok && sif.below_fall)
               state_d = lsg_pkg::LSG_MON_RESET;
            // The configuration being written decides, not the old one
            else if (cfg_wr && wdata_q[`LSG_CFG_TRIP_SEL] && !wdata_q[`LSG_CFG_PWR_DIS] &&
                     !wdata_q[`LSG_CFG_RST_DIS] && (!stop_mode || wdata_q[`LSG_CFG_STOP_EN]) &&
                     !sif.above_rise)
               state_d = lsg_pkg::LSG_MON_RESET;
         end
         lsg_pkg::LSG_MON_RESET:
         begin
            if (sif.above_rise)
               state_d = lsg_pkg::LSG_MON_RUN;
         end
         default:
         begin
            state_d = lsg_pkg::LSG_MON_RUN;
         end
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         flag_q <= `LSG_FLAG_RESET;
         state_q <= lsg_pkg::LSG_MON_RUN;
      end
      else if (ce)
      begin
         flag_q <= flag_d;
         state_q <= state_d;
      end
   end

   // The reset request leaves the block; the flag drives no interrupt
   assign reset_request = (state_q == lsg_pkg::LSG_MON_RESET);

endmodule : lsg_top

`default_nettype wire

//--- lsg_regs.svh
`ifndef LSG_REGS_SVH
`define LSG_REGS_SVH

// Register byte offsets
`define LSG_OFS_STATUS 8'h00
`define LSG_OFS_CONFIG 8'h04

// Status field positions
`define LSG_ST_FLAG 0
`define LSG_ST_RESET 1
`define LSG_ST_LOCKED 2
`define LSG_ST_ACTIVE 3

// Configuration field positions
`define LSG_CFG_PWR_DIS 0
`define LSG_CFG_RST_DIS 1
`define LSG_CFG_STOP_EN 2
`define LSG_CFG_TRIP_SEL 3
`define LSG_CFG_W 4

// Reset values
`define LSG_CFG_RESET 4'h0
`define LSG_FLAG_RESET 1'b0

// Synchroniser depth
`define LSG_SYNC_STAGES 2

// AXI responses
`define LSG_RESP_OKAY 2'h0
`define LSG_RESP_SLVERR 2'h2

`endif

//--- lsg_pkg.sv
`default_nettype none

package lsg_pkg;

   typedef enum logic {
      LSG_MON_RUN,
      LSG_MON_RESET
   } lsg_mon_state_t;

   typedef logic [1:0] lsg_resp_t;

endpackage : lsg_pkg

`default_nettype wire

//--- lsg_sync_if.sv
`timescale 1ns/1ns
`default_nettype none

interface lsg_sync_if;
   logic below_fall;
   logic above_rise;

   modport src (output below_fall, output above_rise);
   modport dst (input below_fall, input above_rise);
endinterface : lsg_sync_if

`default_nettype wire

//--- lsg_sync.sv
`timescale 1ns/1ns
`default_nettype none
`include "lsg_regs.svh"

module lsg_sync #(
   parameter int STAGES = `LSG_SYNC_STAGES
) (
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // Raw comparator levels
   input wire logic raw_below_fall,
   input wire logic raw_above_rise,
   // Synchronised levels
   lsg_sync_if.src sif
);

   logic [1:0] raw;
   logic [1:0] chain_q [STAGES];
   logic [1:0] chain_d [STAGES];

   assign raw = {raw_above_rise, raw_below_fall};

   ////////////////////////////////////////////////////////////////////////
   // Stage 0 reads the raw levels; each later stage reads only the one before it
   genvar s;
   generate
      for (s = 0; s < STAGES; s++)
      begin : g_stage
         always_comb
         begin
            if (s == 0)
               chain_d[s] = raw;
            else
               chain_d[s] = chain_q[(s == 0) ? 0 : s - 1];
         end

         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               chain_q[s] <= 2'h0;
            else if (ce)
               chain_q[s] <= chain_d[s];
         end
      end
   endgenerate

   assign sif.below_fall = chain_q[STAGES-1][0];
   assign sif.above_rise = chain_q[STAGES-1][1];

endmodule : lsg_sync

`default_nettype wire

//--- lsg_chk.sv
`timescale 1ns/1ns
`default_nettype none

module lsg_chk (
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // Bus handshakes
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   // Monitor
   input wire logic raw_below_fall,
   input wire logic raw_above_rise,
   input wire logic trip_range_select,
   input wire logic monitor_enable,
   input wire logic stop_mode,
   input wire logic reset_request
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_trip_clear:
      assert property ($rose(aresetn) |-> !trip_range_select) else $error("trip set out of reset");
   a_rst_hold:
      assert property ($fell(reset_request) |-> $past(raw_above_rise, 3)) else $error("reset left early");
   a_rst_cause:
      assert property ($rose(reset_request) |-> $past(raw_below_fall, 3) || $rose(bvalid))
      else $error("reset without cause");
   a_rst_active:
      assert property ($rose(reset_request) && !$rose(bvalid) |-> $past(monitor_enable))
      else $error("reset while inactive");
   a_en_cause:
      assert property ($changed(monitor_enable) |-> $changed(stop_mode) || $rose(bvalid))
      else $error("enable moved alone");
   a_trip_sticky:
      assert property (trip_range_select |=> trip_range_select) else $error("trip dropped");
   a_trip_write:
      assert property ($rose(trip_range_select) |-> $rose(bvalid)) else $error("trip set without write");
   a_b_drop:
      assert property (ce && bvalid && bready |=> !bvalid) else $error("response held");
   a_r_lat:
      assert property (arvalid && arready |=> rvalid) else $error("read late");
   a_ce_freeze:
      assert property (!ce |=> $stable(reset_request) && $stable(trip_range_select)) else $error("state moved");
   a_ce_ready:
      assert property (!ce |-> !arready) else $error("ready while frozen");

   c_trip: cover property ($rose(trip_range_select));
   c_rst: cover property ($fell(reset_request));
   c_stop: cover property (stop_mode && !monitor_enable);
endmodule : lsg_chk

bind lsg_top lsg_chk u_lsg_chk (
   .aclk(aclk),
   .aresetn(aresetn),
   .ce(ce),
   .bvalid(bvalid),
   .bready(bready),
   .arvalid(arvalid),
   .arready(arready),
   .rvalid(rvalid),
   .raw_below_fall(raw_below_fall),
   .raw_above_rise(raw_above_rise),
   .trip_range_select(trip_range_select),
   .monitor_enable(monitor_enable),
   .stop_mode(stop_mode),
   .reset_request(reset_request)
);

`default_nettype wire

//--- lsg_sim_model.sv
`timescale 1ns/1ns
`default_nettype none

module lsg_sim_model (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bench requests
   input wire logic want_wait,
   input wire logic want_stop,
   // Device side
   input wire logic reset_request,
   output logic wait_mode,
   output logic stop_mode
);
   logic wait_q = 1'h0;
   logic stop_q = 1'h0;
   assign wait_mode = wait_q;
   assign stop_mode = stop_q;
   // Any system reset ends both low-power modes
   always @(posedge aclk)
   begin
      wait_q <= aresetn && !reset_request && (wait_q || want_wait);
      stop_q <= aresetn && !reset_request && (stop_q || want_stop);
   end
endmodule : lsg_sim_model

`default_nettype wire

//--- low_supply_reset_guard_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "lsg_regs.svh"

module low_supply_reset_guard_tb;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rd, r, seed = 32'h5C;
   logic ce = 1'h1;
   logic [3:0] wstrb = 4'hF;
   logic raw_below_fall = 1'h0, raw_above_rise = 1'h1, want_wait = 1'h0, want_stop = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, trip_range_select, monitor_enable;
   logic wait_mode, stop_mode, reset_request, act, stp;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata;
   logic [3:0] c;
   logic [3:0] corner [5] = '{4'h0, 4'h2, 4'h0, 4'h4, 4'h1};
   int error_cnt = 0, n_tests = 0;

   always #20 aclk = ~aclk;

   lsg_top u_lsg_top (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .raw_below_fall(raw_below_fall), .raw_above_rise(raw_above_rise),
      .trip_range_select(trip_range_select), .monitor_enable(monitor_enable),
      .wait_mode(wait_mode), .stop_mode(stop_mode), .reset_request(reset_request)
   );
   lsg_sim_model u_lsg_sim_model (
      .aclk(aclk), .aresetn(aresetn), .want_wait(want_wait), .want_stop(want_stop),
      .reset_request(reset_request), .wait_mode(wait_mode), .stop_mode(stop_mode)
   );

   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // Status word: active, locked, reset, flag
   function automatic logic [31:0] st(input logic f, input logic q, input logic a);
      return {28'h0, a, 1'h1, q, f};
   endfunction : st

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e)
      begin
         error_cnt++;
         $display("unexpected %s: expected %0h seen %0h", n, e, s);
      end
   endtask : chk

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out

   task automatic do_reset();
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
   endtask : do_reset

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      fork
         begin
            do @(posedge aclk); while (!awready);
            awvalid <= 1'h0;
         end
         begin
            do @(posedge aclk); while (!wready);
            wvalid <= 1'h0;
         end
      join
      while (!bvalid) @(posedge aclk);
      rs = bresp;
      bready <= 1'h0;
   endtask : wr

   task automatic rd_reg(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'h0;
      while (!rvalid) @(posedge aclk);
      rd = rdata;
      rs = rresp;
      rready <= 1'h0;
   endtask : rd_reg

   // Comparator levels, then time to pass sync and state
   task automatic step(input logic b, input logic a);
      @(posedge aclk);
      raw_below_fall <= b;
      raw_above_rise <= a;
      repeat (6) @(posedge aclk);
   endtask : step

   ////////////////////////////////////////////////////////////
   initial
   begin
      do_reset();
      rd_reg(`LSG_OFS_STATUS);
      chk("status", 32'h8, rd);
      rd_reg(`LSG_OFS_CONFIG);
      chk("config", 32'h0, rd);
      chk("trip", 32'h0, 32'(trip_range_select));
      rd_reg(8'h10);
      chk("hole resp", 32'(`LSG_RESP_SLVERR), 32'(rs));
      chk("hole data", 32'h0, rd);
      wr(`LSG_OFS_STATUS, 32'hF);
      chk("ro resp", 32'(`LSG_RESP_SLVERR), 32'(rs));
      wstrb <= 4'hE;
      wr(`LSG_OFS_CONFIG, 32'h1);
      chk("strobe resp", 32'h0, 32'(rs));
      wstrb <= 4'hF;
      rd_reg(`LSG_OFS_STATUS);
      chk("strobe lock", 32'h8, rd);
      $display("test basic done");
      raw_above_rise <= 1'h0;
      do_reset();
      wr(`LSG_OFS_CONFIG, 32'hA);
      chk("trip masked", 32'h0, 32'(reset_request));
      do_reset();
      wr(`LSG_OFS_CONFIG, 32'h8);
      chk("trip reset", 32'h1, 32'(reset_request));
      chk("trip", 32'h1, 32'(trip_range_select));
      step(1'h0, 1'h1);
      chk("trip release", 32'h0, 32'(reset_request));
      $display("test trip done");
      // Clock enable low: bus stalls, comparator change held off
      do_reset();
      ce <= 1'h0;
      raw_below_fall <= 1'h1;
      raw_above_rise <= 1'h0;
      fork
         rd_reg(`LSG_OFS_STATUS);
         begin
            repeat (8) @(posedge aclk);
            chk("frozen ready", 32'h0, 32'(arready));
            chk("frozen reset", 32'h0, 32'(reset_request));
            ce <= 1'h1;
         end
      join
      chk("frozen status", 32'h8, rd);
      step(1'h1, 1'h0);
      chk("thawed reset", 32'h1, 32'(reset_request));
      step(1'h0, 1'h1);
      chk("thawed release", 32'h0, 32'(reset_request));
      $display("test enable done");
      for (int i = 0; i < 10; i++)
      begin
         r = rnd();
         c = (i < 5) ? corner[i] : r[3:0];
         stp = (i < 5) ? (i == 2 || i == 3) : r[4];
         do_reset();
         wr(`LSG_OFS_CONFIG, {28'h0, c});
         wr(`LSG_OFS_CONFIG, {28'h0, ~c});
         chk("relock resp", 32'h0, 32'(rs));
         rd_reg(`LSG_OFS_CONFIG);
         chk("config", {28'h0, c}, rd);
         chk("trip", 32'(c[3]), 32'(trip_range_select));
         @(posedge aclk);
         want_stop <= stp;
         want_wait <= r[5];
         @(posedge aclk);
         want_stop <= 1'h0;
         want_wait <= 1'h0;
         act = !c[0] && (!stp || c[2]);
         step(1'h1, 1'h0);
         chk("enable", 32'(act), 32'(monitor_enable));
         rd_reg(`LSG_OFS_STATUS);
         chk("low", st(act, act && !c[1], act), rd);
         step(1'h0, 1'h0);
         rd_reg(`LSG_OFS_STATUS);
         chk("between", st(act, act && !c[1], act), rd);
         step(1'h0, 1'h1);
         rd_reg(`LSG_OFS_STATUS);
         chk("high", st(1'h0, 1'h0, act), rd);
         $display("test %0d done", i);
      end
      close_out();
   end

   initial
   begin
      #200000;
      error_cnt++;
      close_out();
   end
endmodule : low_supply_reset_guard_tb

`default_nettype wire
